/* File: hdl/spi_slave_core.sv */
// Serial peripheral slave core with transfer flag handling and error flags.
//
// Function
// RULE_01 - Done flag clears after status access while set, then data read or write.
// RULE_02 - While done flag set, data writes ignored until status register read.
// RULE_03 - In slave mode the serial clock is an input from the master.
// RULE_04 - Software sets idle level and capture edge, then slave mode with port on.
// RULE_05 - Master holds select low per byte or per exchange, by capture edge.
// RULE_06 - Data write loads the shift register; bits leave on MISO, MSB first.
// RULE_07 - A slave transfer begins only on serial clock edges from the master.
// RULE_08 - Byte completion sets done flag; interrupt if enabled and CPU unmasked.
// RULE_09 - Software must clear done before a second byte completes.
// RULE_10 - Idle level and capture edge together choose the capture clock edge.
// RULE_11 - The idle clock line is pulled to the selected idle level.
// RULE_12 - Software disables the port before changing the idle level.
// RULE_13 - Master with select low sets mode fault; interrupt if enabled.
// RULE_14 - Mode fault clears port enable and master select.
// RULE_15 - Mode fault clears after status read while set, then control write.
// RULE_16 - While mode fault set, port and master bits cannot be set outside clearing.
// RULE_17 - Select held high during the mode fault clearing sequence.
// RULE_18 - Byte completing while done flag still set raises overrun.
// RULE_19 - On overrun the receive buffer keeps the first byte; later bytes lost.
// RULE_20 - Overrun flag clears on a status register read.
// RULE_21 - Data write during a transfer is discarded and sets write collision only.
// RULE_22 - Wait mode changes nothing; halt freezes all state; the pin synchroniser keeps sampling the pins during halt.
// RULE_23 - Select source bit picks the soft select level over the pin.
// RULE_24 - Interrupt enable gates one request from done, fault or overrun.
// RULE_25 - Received byte enters the receive buffer as the done flag sets.
`timescale 1ns/100ps
`default_nettype none
`include "spi_slave_defs.svh"
module spi_slave_core #(
  parameter int FRAME_BITS = `SPI_FRAME_BITS
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Register access strobes from the CPU, one cycle each.
  input wire logic ctrl_wr_i,
  input wire logic csr_rd_i,
  input wire logic csr_wr_i,
  input wire logic data_rd_i,
  input wire logic data_wr_i,
  input wire logic [7:0] wdata_i,
  output spi_slave_pkg::ctrl_reg_type ctrl_o,
  output spi_slave_pkg::csr_reg_type csr_o,
  output logic [7:0] data_o,
  // CPU side power and interrupt signals.
  input wire logic cpu_irq_mask_i,
  input wire logic halt_i,
  output logic irq_o,
  output logic halt_wake_o,
  // Serial pins.
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic sel_n_i,
  output logic miso_o,
  output logic miso_oe_o
);

  // ==========================================================================
  // Pin synchronisation
  // ==========================================================================

  spi_slave_pkg::pins_type pins_raw;
  spi_slave_pkg::pins_type pins;

  // Pins arrive from the master's clock domain and pass two flip-flops.
  assign pins_raw = '{sel_n: sel_n_i, sck: sck_i, mosi: mosi_i}; // [RULE_03]

  pin_sync #(
    .WIDTH(3),
    .RESET_VAL(`SPI_PIN_RESET)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .async_i(pins_raw),
    .sync_o(pins)
  );

  // ==========================================================================
  // Register state
  // ==========================================================================

  spi_slave_pkg::ctrl_reg_type ctrl_q;
  spi_slave_pkg::ctrl_reg_type ctrl_d;
  logic [2:0] cfg_q;
  logic [2:0] cfg_d;
  logic done_q;
  logic done_d;
  logic write_collision_flag_q;
  logic write_collision_flag_d;
  logic ovr_q;
  logic ovr_d;
  logic mode_fault_flag_q;
  logic mode_fault_flag_d;
  logic done_armed_q;
  logic done_armed_d;
  logic csr_seen_q;
  logic csr_seen_d;
  logic write_collision_flag_armed_q;
  logic write_collision_flag_armed_d;
  logic mode_fault_flag_armed_q;
  logic mode_fault_flag_armed_d;
  logic [7:0] rx_buf_q;
  logic [7:0] rx_buf_d;

  // ==========================================================================
  // Serial state
  // ==========================================================================

  logic [FRAME_BITS-1:0] tx_q;
  logic [FRAME_BITS-1:0] tx_d;
  logic [FRAME_BITS-1:0] rx_q;
  logic [FRAME_BITS-1:0] rx_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic busy_q;
  logic busy_d;
  logic sck_prev_q;
  logic sck_prev_d;

  // ==========================================================================
  // Decode of selection, clock edges and accesses
  // ==========================================================================

  logic sel_low;
  logic slave_on;
  logic sck_change;
  logic lead_edge;
  logic trail_edge;
  logic sample_edge;
  logic drive_edge;
  logic busy_eff;
  logic wr_take;
  logic collide;
  logic load;
  logic complete;
  logic done_clr;
  logic fault;

  // Internal select: the soft level when chosen, else the pin; low means selected.
  assign sel_low = cfg_q[1] ? ~cfg_q[0] : ~pins.sel_n; // [RULE_23]
  assign slave_on = ctrl_q.port_en & ~ctrl_q.master_sel & sel_low;

  // Leading edge leaves the idle level, trailing edge returns to it.
  assign sck_change = pins.sck ^ sck_prev_q;
  assign lead_edge = sck_change & (sck_prev_q == ctrl_q.idle_level);
  assign trail_edge = sck_change & (sck_prev_q != ctrl_q.idle_level);

  // Capture on the first or second transition, drive on the other one.
  assign sample_edge = ctrl_q.capture_edge ? trail_edge : lead_edge; // [RULE_10]
  assign drive_edge = ctrl_q.capture_edge ? lead_edge : trail_edge; // [RULE_10]

  // First-edge capture counts as busy for the whole selected time.
  assign busy_eff = busy_q | (slave_on & ~ctrl_q.capture_edge);

  // Writes are inhibited while done is set until the status register is read.
  assign wr_take = data_wr_i & ~(done_q & ~csr_seen_q) & ~halt_i; // [RULE_02]
  assign collide = wr_take & busy_eff; // [RULE_21]
  assign load = wr_take & ~busy_eff; // [RULE_06]

  // The eighth capture edge of a selected frame completes a byte.
  assign complete = slave_on & sample_edge & (cnt_q == `SPI_LAST_BIT) & ~halt_i; // [RULE_07]

  // Done clears on a data access once the status register was accessed.
  assign done_clr = done_armed_q & (data_rd_i | data_wr_i) & ~halt_i; // [RULE_01]

  // A master that sees its select low has a mode fault.
  assign fault = ctrl_q.master_sel & sel_low & ~halt_i; // [RULE_13]

  // ==========================================================================
  // Shift engine
  // ==========================================================================

  // Next state of the shifters, bit counter and busy flag.
  always_comb begin
    tx_d = tx_q;
    rx_d = rx_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    sck_prev_d = sck_prev_q;
    if (!halt_i) begin // [RULE_22]
      sck_prev_d = pins.sck;
      if (!slave_on) begin
        // Deselection or a disabled port abandons a partial byte.
        cnt_d = 3'h0;
        busy_d = 1'b0;
      end else begin
        if (lead_edge || trail_edge) begin
          busy_d = 1'b1; // [RULE_07]
        end
        if (sample_edge) begin
          rx_d = {rx_q[FRAME_BITS-2:0], pins.mosi};
          if (cnt_q == `SPI_LAST_BIT) begin
            cnt_d = 3'h0;
            busy_d = 1'b0;
            // The shifter keeps the byte just received, so an unwritten slave echoes it.
            tx_d = {rx_q[FRAME_BITS-2:0], pins.mosi}; // [RULE_06]
          end else begin
            cnt_d = cnt_q + 3'h1;
          end
        end
        // A drive edge before the first or after the last capture shifts nothing.
        if (drive_edge && (cnt_q != 3'h0)) begin
          tx_d = {tx_q[FRAME_BITS-2:0], 1'b0}; // [RULE_06]
        end
      end
      if (load) begin
        tx_d = wdata_i; // [RULE_06]
      end
    end
  end

  // Registers of the shift engine.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_q <= `SPI_DATA_RESET;
      rx_q <= `SPI_DATA_RESET;
      cnt_q <= 3'h0;
      busy_q <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      rx_q <= rx_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      sck_prev_q <= sck_prev_d;
    end
  end

  // ==========================================================================
  // Registers and flags
  // ==========================================================================

  // Next values of the control bits, configuration bits and status flags.
  always_comb begin
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    done_d = done_q;
    write_collision_flag_d = write_collision_flag_q;
    ovr_d = ovr_q;
    mode_fault_flag_d = mode_fault_flag_q;
    done_armed_d = done_armed_q;
    csr_seen_d = csr_seen_q;
    write_collision_flag_armed_d = write_collision_flag_armed_q;
    mode_fault_flag_armed_d = mode_fault_flag_armed_q;
    rx_buf_d = rx_buf_q;
    if (!halt_i) begin // [RULE_22]
      // Control write; a pending fault keeps port and master bits low.
      if (ctrl_wr_i) begin
        ctrl_d = wdata_i;
        if (mode_fault_flag_q && !mode_fault_flag_armed_q) begin
          ctrl_d.port_en = 1'b0; // [RULE_16]
          ctrl_d.master_sel = 1'b0; // [RULE_16]
        end
      end
      if (csr_wr_i) begin
        cfg_d = wdata_i[2:0];
      end

      // Done flag: the new completion wins over a clear.
      if (done_clr) begin
        done_d = 1'b0; // [RULE_01]
        done_armed_d = 1'b0;
        csr_seen_d = 1'b0;
      end
      if ((csr_rd_i || csr_wr_i) && done_q && !done_clr) begin
        done_armed_d = 1'b1; // [RULE_01]
      end
      if (csr_rd_i && done_q && !done_clr) begin
        csr_seen_d = 1'b1; // [RULE_02]
      end
      if (complete) begin
        done_d = 1'b1; // [RULE_08]
        done_armed_d = 1'b0;
        csr_seen_d = 1'b0;
      end

      // Receive buffer keeps the first byte while done is pending.
      if (complete && !(done_q && !done_clr)) begin
        rx_buf_d = {rx_q[FRAME_BITS-2:0], pins.mosi}; // [RULE_25]
      end

      // Overrun: a status read clears, a late completion sets and wins.
      if (csr_rd_i) begin
        ovr_d = 1'b0; // [RULE_20]
      end
      if (complete && done_q && !done_clr) begin
        ovr_d = 1'b1; // [RULE_18] [RULE_19]
      end

      // Write collision: status read arms, data read clears, a collision sets.
      if (csr_rd_i && write_collision_flag_q) begin
        write_collision_flag_armed_d = 1'b1;
      end
      if (write_collision_flag_armed_q && data_rd_i) begin
        write_collision_flag_d = 1'b0;
        write_collision_flag_armed_d = 1'b0;
      end
      if (collide) begin
        write_collision_flag_d = 1'b1; // [RULE_21]
      end

      // Mode fault: status read arms, control write clears, a fault sets.
      if (csr_rd_i && mode_fault_flag_q) begin
        mode_fault_flag_armed_d = 1'b1; // [RULE_15]
      end
      if (mode_fault_flag_armed_q && ctrl_wr_i) begin
        mode_fault_flag_d = 1'b0; // [RULE_15]
        mode_fault_flag_armed_d = 1'b0;
      end
      if (fault) begin
        mode_fault_flag_d = 1'b1; // [RULE_13]
        ctrl_d.port_en = 1'b0; // [RULE_14]
        ctrl_d.master_sel = 1'b0; // [RULE_14]
      end
    end
  end

  // Registers of the CPU-facing state.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ctrl_q <= `SPI_CTRL_RESET;
      cfg_q <= 3'h0;
      done_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      ovr_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
      done_armed_q <= 1'b0;
      csr_seen_q <= 1'b0;
      write_collision_flag_armed_q <= 1'b0;
      mode_fault_flag_armed_q <= 1'b0;
      rx_buf_q <= `SPI_DATA_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
      done_q <= done_d;
      write_collision_flag_q <= write_collision_flag_d;
      ovr_q <= ovr_d;
      mode_fault_flag_q <= mode_fault_flag_d;
      done_armed_q <= done_armed_d;
      csr_seen_q <= csr_seen_d;
      write_collision_flag_armed_q <= write_collision_flag_armed_d;
      mode_fault_flag_armed_q <= mode_fault_flag_armed_d;
      rx_buf_q <= rx_buf_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================

  // Register views; the reserved bit reads zero.
  assign ctrl_o = ctrl_q;
  assign csr_o = '{done: done_q, write_collision_flag: write_collision_flag_q, overrun_flag: ovr_q, mode_fault_flag: mode_fault_flag_q, rsvd: 1'b0,
                   out_dis: cfg_q[2], sel_src: cfg_q[1], soft_sel: cfg_q[0]};
  assign data_o = rx_buf_q;

  // One request for done, fault and overrun; collision never interrupts.
  assign irq_o = ctrl_q.irq_en & (done_q | mode_fault_flag_q | ovr_q) & ~cpu_irq_mask_i; // [RULE_24] [RULE_08]

  // While halted, selected clock activity asks the system to wake.
  assign halt_wake_o = halt_i & slave_on & sck_change; // [RULE_22]

  // MISO carries the shifter's top bit while selected and enabled.
  assign miso_o = tx_q[FRAME_BITS-1]; // [RULE_06]
  assign miso_oe_o = slave_on & ~cfg_q[2];

endmodule : spi_slave_core
`default_nettype wire

/* File: shared/spi_slave_defs.svh */
// Constants for the serial peripheral slave core: widths, field positions, reset values.
`ifndef SPI_SLAVE_DEFS_SVH
`define SPI_SLAVE_DEFS_SVH

// Number of bits in one serial frame.
`define SPI_FRAME_BITS 8
// Last bit index of a frame counter.
`define SPI_LAST_BIT 3'h7

// Field positions in the serial control register.
`define SPI_CTRL_IRQ_EN_POS 7
`define SPI_CTRL_PORT_EN_POS 6
`define SPI_CTRL_MASTER_POS 4
`define SPI_CTRL_IDLE_POS 3
`define SPI_CTRL_CAPTURE_POS 2

// Field positions in the control/status register.
`define SPI_CSR_DONE_POS 7
`define SPI_CSR_WRITE_COLLISION_FLAG_POS 6
`define SPI_CSR_OVR_POS 5
`define SPI_CSR_MODE_FAULT_FLAG_POS 4

// Reset values.
`define SPI_CTRL_RESET 8'h00
`define SPI_CSR_RESET 8'h00
`define SPI_DATA_RESET 8'h00
// Pin synchroniser reset levels: select high, clock low, data low.
`define SPI_PIN_RESET 3'h4

`endif

/* File: shared/spi_slave_pkg.sv */
// Types shared by the serial peripheral slave core.
`default_nettype none
package spi_slave_pkg;

  // Serial control register layout, most significant bit first.
  typedef struct packed {
    logic irq_en;
    logic port_en;
    logic div_en;
    logic master_sel;
    logic idle_level;
    logic capture_edge;
    logic [1:0] rate;
  } ctrl_reg_type;

  // Control/status register layout, most significant bit first.
  typedef struct packed {
    logic done;
    logic write_collision_flag;
    logic overrun_flag;
    logic mode_fault_flag;
    logic rsvd;
    logic out_dis;
    logic sel_src;
    logic soft_sel;
  } csr_reg_type;

  // Synchronised pin levels.
  typedef struct packed {
    logic sel_n;
    logic sck;
    logic mosi;
  } pins_type;

endpackage : spi_slave_pkg
`default_nettype wire

/* File: hdl/pin_sync.sv */
// Two-stage synchroniser for pins that arrive from outside the core clock domain.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  // Both stages take the idle pin levels under reset.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule : pin_sync
`default_nettype wire

/* File: verification/spi_master_model.sv */
// External serial master model that clocks bytes through the slave core.
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
  output logic sck_o,
  output logic mosi_o,
  output logic sel_n_o,
  input wire logic miso_i
);
  // =============
  // Idle state: deselected, clock parked low.
  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    sel_n_o = 1'b1;
  end

  // Drives the select line alone.
  task sel(input logic lvl);
    sel_n_o = lvl;
  endtask : sel

  // Sends one byte MSB first; the clock only runs inside the frame.
  task xfer(input logic pol, input logic pha, input logic [7:0] tx, output logic [7:0] rx);
    sck_o = pol;
    #160;
    sel_n_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (!pha) mosi_o = tx[i];
      #80 sck_o = !pol;
      if (pha) mosi_o = tx[i];
      else rx[i] = miso_i;
      #80 sck_o = pol;
      if (pha) rx[i] = miso_i;
    end
    #80 sel_n_o = 1'b1;
    mosi_o = !mosi_o;
  endtask : xfer
endmodule : spi_master_model
`default_nettype wire

/* File: verification/spi_slave_core_chk.sv */
// Concurrent checks on the ports of the serial slave core.
`timescale 1ns/100ps
`default_nettype none
module spi_slave_core_chk (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic csr_rd_i,
  input wire logic data_rd_i,
  input wire logic data_wr_i,
  input wire logic cpu_irq_mask_i,
  input wire logic halt_i,
  input wire spi_slave_pkg::ctrl_reg_type ctrl_o,
  input wire spi_slave_pkg::csr_reg_type csr_o,
  input wire logic [7:0] data_o,
  input wire logic irq_o,
  input wire logic miso_oe_o
);
  // =============
  // All checks run on the core clock and rest during reset.
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  // Status access while done is up, then a data read.
  sequence done_clear_seq;
    csr_rd_i && csr_o.done && !halt_i ##[1:2] data_rd_i && !halt_i;
  endsequence

  chk_irq_gate: assert property (
    irq_o == (ctrl_o.irq_en && !cpu_irq_mask_i && (csr_o.done || csr_o.mode_fault_flag || csr_o.overrun_flag)))
    else $error("irq level wrong");
  chk_write_collision_flag_noirq: assert property (
    $rose(csr_o.write_collision_flag) && !csr_o.done && !csr_o.mode_fault_flag && !csr_o.overrun_flag |-> !irq_o)
    else $error("irq on collision");
  chk_write_collision_flag_cause: assert property ($rose(csr_o.write_collision_flag) |-> $past(data_wr_i))
    else $error("collision without write");
  chk_mode_fault_flag_cause: assert property ($rose(csr_o.mode_fault_flag) |-> $past(ctrl_o.master_sel))
    else $error("fault outside master");
  chk_mode_fault_flag_clears: assert property (
    $rose(csr_o.mode_fault_flag) |-> ##[0:1] !ctrl_o.port_en && !ctrl_o.master_sel)
    else $error("fault kept port on");
  chk_ovr_cause: assert property ($rose(csr_o.overrun_flag) |-> $past(csr_o.done))
    else $error("overrun without done");
  chk_ovr_clear: assert property (csr_rd_i && !halt_i && csr_o.overrun_flag |=> !csr_o.overrun_flag)
    else $error("overrun not cleared");
  chk_done_clear: assert property (done_clear_seq |=> !csr_o.done)
    else $error("done not cleared");
  chk_rx_update: assert property (!$stable(data_o) |-> $rose(csr_o.done))
    else $error("buffer changed off done");
  chk_halt_freeze: assert property (
    halt_i |=> $stable(csr_o) && $stable(ctrl_o) && $stable(data_o))
    else $error("state moved in halt");
  chk_oe_gate: assert property (
    miso_oe_o |-> ctrl_o.port_en && !ctrl_o.master_sel && !csr_o.out_dis)
    else $error("output drive not allowed");
endmodule : spi_slave_core_chk

bind spi_slave_core spi_slave_core_chk spi_slave_core_chk_i (.core_clk_i, .srst_i,
  .csr_rd_i, .data_rd_i, .data_wr_i, .cpu_irq_mask_i, .halt_i, .ctrl_o, .csr_o,
  .data_o, .irq_o, .miso_oe_o);
`default_nettype wire

/* File: verification/test_spi_slave_core.sv */
// Self-checking bench for the serial slave core with an external master model.
`timescale 1ns/100ps
`default_nettype none
module test_spi_slave_core;
  // =============
  // Stimulus and observed signals.
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [4:0] strb = 5'h00;
  logic [7:0] wdata_i = 8'h00;
  logic cpu_irq_mask_i = 1'b0;
  logic halt_i = 1'b0;
  logic sck_i, mosi_i, sel_n_i, miso_o, miso_oe_o, irq_o, halt_wake_o;
  spi_slave_pkg::ctrl_reg_type ctrl_o;
  spi_slave_pkg::csr_reg_type csr_o;
  logic [7:0] data_o, rx;
  int fails = 0;
  int n_tests = 0;
  localparam logic [4:0] CW = 5'h01, CR = 5'h02, SW = 5'h04, DR = 5'h08, DW = 5'h10;
  // A released data line floats, so an idle output never passes a compare.
  wire logic miso_w = miso_oe_o ? miso_o : 1'bz;

  // Core clock toggles every half period.
  always #5 core_clk_i = !core_clk_i;

  // Device and far-end master.
  spi_slave_core spi_slave_core_i (.core_clk_i, .srst_i, .ctrl_wr_i(strb[0]), .csr_rd_i(strb[1]),
    .csr_wr_i(strb[2]), .data_rd_i(strb[3]), .data_wr_i(strb[4]), .wdata_i, .ctrl_o, .csr_o,
    .data_o, .cpu_irq_mask_i, .halt_i, .irq_o, .halt_wake_o, .sck_i, .mosi_i, .sel_n_i,
    .miso_o, .miso_oe_o);
  spi_master_model spi_master_model_i (.sck_o(sck_i), .mosi_o(mosi_i), .sel_n_o(sel_n_i),
    .miso_i(miso_w));

  // =============
  // Shared tasks.
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task end_sim;
    $display("checks=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // One register strobe, raised and dropped on falling edges.
  task acc(input logic [4:0] s, input logic [7:0] d);
    @(negedge core_clk_i);
    strb = s;
    wdata_i = d;
    @(negedge core_clk_i);
    strb = 5'h00;
  endtask : acc

  task wait_done;
    int k;
    @(negedge core_clk_i);
    for (k = 0; k < 40 && csr_o.done !== 1'b1; k++) @(negedge core_clk_i);
    if (k == 40) begin
      fails++;
      end_sim();
    end
  endtask : wait_done

  // Status read then data read drops the done flag.
  task clr;
    acc(CR, 8'h00);
    acc(DR, 8'h00);
  endtask : clr

  // =============
  // Scenarios.
  task t_reset;
    chk(ctrl_o, 8'h00);
    chk(csr_o, 8'h00);
    chk(data_o, 8'h00);
    chk(irq_o, 8'h00);
  endtask : t_reset

  task t_modes;
    logic [7:0] tx;
    for (int m = 0; m < 4; m++) begin
      tx = 8'h96 ^ 8'(m);
      acc(CW, 8'h00);
      acc(CW, {4'hC, m[1], m[0], 2'b00});
      acc(DW, tx);
      spi_master_model_i.xfer(m[1], m[0], 8'h3C + 8'(m), rx);
      wait_done();
      chk(rx, tx);
      chk(data_o, 8'h3C + 8'(m));
      chk(irq_o, 8'h01);
      cpu_irq_mask_i = 1'b1;
      #1;
      chk(irq_o, 8'h00);
      @(negedge core_clk_i);
      cpu_irq_mask_i = 1'b0;
      clr();
      chk(csr_o, 8'h00);
    end
  endtask : t_modes

  task t_ovr;
    spi_master_model_i.xfer(1'b1, 1'b1, 8'hA5, rx);
    wait_done();
    chk(rx, 8'h3F);
    acc(DW, 8'hFF);
    chk(csr_o, 8'h80);
    clr();
    spi_master_model_i.xfer(1'b1, 1'b1, 8'h5A, rx);
    wait_done();
    chk(rx, 8'hA5);
    spi_master_model_i.xfer(1'b1, 1'b1, 8'hC3, rx);
    wait_done();
    chk(csr_o, 8'hA0);
    chk(data_o, 8'h5A);
    acc(CR, 8'h00);
    chk(csr_o, 8'h80);
    acc(DR, 8'h00);
    chk(csr_o, 8'h00);
  endtask : t_ovr

  task t_write_collision_flag;
    acc(DW, 8'h66);
    fork
      spi_master_model_i.xfer(1'b1, 1'b1, 8'h81, rx);
      begin
        repeat (60) @(negedge core_clk_i);
        acc(DW, 8'h00);
        chk(csr_o, 8'h40);
        chk(irq_o, 8'h00);
      end
    join
    wait_done();
    chk(rx, 8'h66);
    chk(data_o, 8'h81);
    clr();
    chk(csr_o, 8'h00);
  endtask : t_write_collision_flag

  task t_soft;
    acc(SW, 8'h03);
    spi_master_model_i.xfer(1'b1, 1'b1, 8'h11, rx);
    repeat (8) @(negedge core_clk_i);
    chk(csr_o, 8'h03);
    chk(data_o, 8'h81);
    acc(SW, 8'h00);
  endtask : t_soft

  task t_mode_fault_flag;
    spi_master_model_i.sel(1'b0);
    acc(CW, 8'hD0);
    repeat (8) @(negedge core_clk_i);
    chk(csr_o, 8'h10);
    chk(ctrl_o, 8'h80);
    chk(irq_o, 8'h01);
    spi_master_model_i.sel(1'b1);
    acc(CW, 8'hD0);
    chk(ctrl_o, 8'h80);
    repeat (4) @(negedge core_clk_i);
    acc(CR, 8'h00);
    acc(CW, 8'h40);
    chk(csr_o, 8'h00);
    chk(ctrl_o, 8'h40);
  endtask : t_mode_fault_flag

  task t_halt;
    logic woke;
    woke = 1'b0;
    @(negedge core_clk_i);
    halt_i = 1'b1;
    // Selected clock activity while halted must raise the wake request.
    fork
      spi_master_model_i.xfer(1'b0, 1'b0, 8'h99, rx);
      repeat (150) @(negedge core_clk_i) woke |= halt_wake_o;
    join
    chk(woke, 8'h01);
    acc(CW, 8'h00);
    repeat (8) @(negedge core_clk_i);
    chk(csr_o, 8'h00);
    chk(ctrl_o, 8'h40);
    chk(data_o, 8'h81);
    halt_i = 1'b0;
  endtask : t_halt

  // Main sequence.
  initial begin
    repeat (10) @(negedge core_clk_i);
    srst_i = 1'b0;
    t_reset();
    t_modes();
    t_ovr();
    t_write_collision_flag();
    t_soft();
    t_mode_fault_flag();
    t_halt();
    end_sim();
  end
endmodule : test_spi_slave_core
`default_nettype wire
